//--- core/fcs_framer.sv
// Frame configuration header and media slot framer on transmit; header, count and bitmap only on receive
`timescale 1ns/1ps
module fcs_framer (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Local configuration
   input wire logic network_timing_master,
   input wire logic [3:0] cfg_base_rate,
   input wire logic [3:0] cfg_bandwidth,
   input wire logic [1:0] cfg_slot_format,
   input wire logic [2:0] cfg_tc_type,
   input wire logic [2:0] cfg_tc_rate,
   input wire logic [3:0] cfg_cable,
   input wire logic cfg_copy_protect,
   input wire logic [31:0] cfg_timecode,
   input wire logic bw_override_en,
   input wire logic [5:0] bw_override,
   // Slot samples in: index and data
   input wire logic slot_in_valid,
   input wire logic [4:0] slot_in_index,
   input wire logic [31:0] slot_in_data,
   output logic slot_in_ready,
   // Transmit word stream towards IN-port neighbours
   output logic tx_valid,
   output logic [31:0] tx_word,
   output logic tx_sof,
   output logic tx_eof,
   input wire logic tx_ready,
   // Receive word stream from the OUT-port neighbour
   input wire logic rx_valid,
   input wire logic rx_sof,
   input wire logic [31:0] rx_word,
   // Received configuration and status
   output logic [3:0] rx_base_rate,
   output logic [3:0] rx_bandwidth,
   output logic [2:0] rx_tc_type,
   output logic [2:0] rx_tc_rate,
   output logic [3:0] rx_cable,
   output logic [31:0] rx_count,
   output logic [31:0] rx_slot_map,
   output logic rx_version_bad,
   output logic rx_unsupported,
   output logic retransmit_allow,
   output logic [5:0] slots_per_channel,
   output logic [31:0] tx_frame_count
);
   // ==========================================================
   // Reset release through two flip-flops
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ==========================================================
   // Slot sample FIFO; the slot store drains it only between frames
   logic fifo_valid;
   logic [fcs_pkg::FIFO_W-1:0] fifo_data;
   logic fifo_ready;

   fcs_fifo #(
      .WIDTH(fcs_pkg::FIFO_W),
      .DEPTH(fcs_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_valid(slot_in_valid),
      .in_data({slot_in_index, slot_in_data}),
      .in_ready(slot_in_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(fifo_ready)
   );

   // ==========================================================
   // Effective base rate: own when master, forwarded otherwise
   logic [3:0] tx_base_rate;
   logic [7:0] period;
   logic [7:0] div_cnt;
   logic frame_tick;
   logic rx_hdr_ok;

   assign tx_base_rate = network_timing_master ? cfg_base_rate : rx_base_rate;
   assign period = (tx_base_rate == fcs_pkg::RATE_44K1) ? fcs_pkg::PERIOD44
                                                        : fcs_pkg::PERIOD48;

   // Frame-rate divider; a slave realigns to each received header with the right version
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_cnt <= '0;
         frame_tick <= 1'b0;
      end
      else
      begin
         frame_tick <= 1'b0;
         if (!network_timing_master && rx_hdr_ok)
            div_cnt <= 8'h01;
         else if (div_cnt >= period - 8'h01)
         begin
            div_cnt <= '0;
            frame_tick <= 1'b1;
         end
         else
            div_cnt <= div_cnt + 8'h01;
      end
   end

   // ==========================================================
   // Slot store: 32 words plus a valid bit per slot
   logic [31:0] slot_mem [fcs_pkg::NUM_SLOTS];
   logic [31:0] slot_valid;
   logic [31:0] map_snap;
   logic [4:0] slot_idx;
   fcs_pkg::fcs_tx_state_t state;
   logic advance;
   logic fifo_take;

   assign fifo_ready = (state == fcs_pkg::FCS_IDLE) && !frame_tick;
   assign fifo_take = fifo_valid && fifo_ready;

   // Slot data storage
   always_ff @(posedge clk_sys)
   begin
      if (fifo_take)
         slot_mem[fifo_data[36:32]] <= fifo_data[31:0];
   end

   // Valid bits set on store, cleared when the snapshot takes them at frame start; the snapshot freezes them
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slot_valid <= '0;
         map_snap <= '0;
      end
      else if (frame_tick && state == fcs_pkg::FCS_IDLE && advance) // A dropped tick keeps the bits
      begin
         map_snap <= slot_valid;
         slot_valid <= '0;
      end
      else if (fifo_take)
         slot_valid[fifo_data[36:32]] <= 1'b1;
   end

   // ==========================================================
   // Transmit sequencer: header, count, bitmap, then 32 slots
   logic [31:0] hdr_word;
   logic [31:0] next_word;
   logic tc_is_count;

   assign advance = !tx_valid || tx_ready;
   assign tc_is_count = (cfg_tc_type == fcs_pkg::TCTYPE_COUNT);

   // Header word; octet 30 leads in bits 31:24, reserved bits held zero
   always_comb
   begin
      hdr_word = '0;
      hdr_word[fcs_pkg::VER_LSB +: 4] = fcs_pkg::FRAME_VERSION;
      hdr_word[fcs_pkg::FMT_LSB +: 2] = cfg_slot_format;
      hdr_word[fcs_pkg::CP_BIT] = cfg_copy_protect;
      hdr_word[fcs_pkg::RATE_LSB +: 4] = tx_base_rate;
      hdr_word[fcs_pkg::BW_LSB +: 4] = cfg_bandwidth;
      hdr_word[fcs_pkg::TCTYPE_LSB +: 3] = cfg_tc_type;
      hdr_word[fcs_pkg::TCRATE_LSB +: 3] = cfg_tc_rate;
      hdr_word[fcs_pkg::CABLE_LSB +: 4] = cfg_cable;
   end

   // Word chosen for the next beat of the current state
   always_comb
   begin
      unique case (state)
         fcs_pkg::FCS_IDLE: next_word = hdr_word;
         fcs_pkg::FCS_HDR: next_word = tc_is_count ? tx_frame_count : cfg_timecode;
         fcs_pkg::FCS_CNT: next_word = map_snap;
         fcs_pkg::FCS_MAP,
         fcs_pkg::FCS_SLOT: next_word = map_snap[slot_idx] ? slot_mem[slot_idx] : '0;
         default: next_word = '0;
      endcase
   end

   // State and output beat; a stalled link simply holds the beat
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= fcs_pkg::FCS_IDLE;
         slot_idx <= '0;
         tx_valid <= 1'b0;
         tx_word <= '0;
         tx_sof <= 1'b0;
         tx_eof <= 1'b0;
      end
      else if (advance)
      begin
         tx_valid <= 1'b0;
         tx_sof <= 1'b0;
         tx_eof <= 1'b0;
         unique case (state)
            fcs_pkg::FCS_IDLE:
            begin
               if (frame_tick)
               begin
                  tx_valid <= 1'b1;
                  tx_sof <= 1'b1;
                  tx_word <= next_word;
                  state <= fcs_pkg::FCS_HDR;
               end
            end
            fcs_pkg::FCS_HDR:
            begin
               tx_valid <= 1'b1;
               tx_word <= next_word;
               state <= fcs_pkg::FCS_CNT;
            end
            fcs_pkg::FCS_CNT:
            begin
               tx_valid <= 1'b1;
               tx_word <= next_word;
               slot_idx <= '0;
               state <= fcs_pkg::FCS_MAP;
            end
            fcs_pkg::FCS_MAP,
            fcs_pkg::FCS_SLOT:
            begin
               tx_valid <= 1'b1;
               tx_word <= next_word;
               slot_idx <= slot_idx + 5'h01;
               state <= fcs_pkg::FCS_SLOT;
               if (slot_idx == 5'h1f)
               begin
                  tx_eof <= 1'b1;
                  state <= fcs_pkg::FCS_IDLE;
               end
            end
            default: state <= fcs_pkg::FCS_IDLE;
         endcase
      end
   end

   // Frame counter: one step per header sent, wrapping naturally
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         tx_frame_count <= '0;
      else if (advance && state == fcs_pkg::FCS_HDR)
         tx_frame_count <= tx_frame_count + 32'h1;
   end

   // ==========================================================
   // Receive parser: header checks, then count and bitmap words
   logic [1:0] rx_pos;
   logic ver_ok;
   logic code_bad;
   logic [3:0] f_rate;
   logic [3:0] f_bw;
   logic [2:0] f_type;
   logic [2:0] f_tcr;

   assign f_rate = rx_word[fcs_pkg::RATE_LSB +: 4];
   assign f_bw = rx_word[fcs_pkg::BW_LSB +: 4];
   assign f_type = rx_word[fcs_pkg::TCTYPE_LSB +: 3];
   assign f_tcr = rx_word[fcs_pkg::TCRATE_LSB +: 3];
   assign ver_ok = (rx_word[fcs_pkg::VER_LSB +: 4] == fcs_pkg::FRAME_VERSION);
   assign rx_hdr_ok = rx_valid && rx_sof && ver_ok;
   // Reserved codes in any of the four coded fields
   assign code_bad = (f_rate > fcs_pkg::RATE_44K1) || (f_bw > fcs_pkg::BW_MAX)
                     || (f_type > fcs_pkg::TCTYPE_MAX) || (f_tcr > fcs_pkg::TCRATE_MAX);

   // Header capture; reserved bits are never looked at
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_base_rate <= fcs_pkg::RATE_48K;
         rx_bandwidth <= '0;
         rx_tc_type <= '0;
         rx_tc_rate <= '0;
         rx_cable <= '0;
         rx_version_bad <= 1'b0;
         rx_unsupported <= 1'b0;
         retransmit_allow <= 1'b1;
      end
      else if (rx_valid && rx_sof)
      begin
         rx_version_bad <= !ver_ok;
         if (ver_ok)
         begin
            retransmit_allow <= !rx_word[fcs_pkg::CP_BIT];
            rx_cable <= rx_word[fcs_pkg::CABLE_LSB +: 4];
            rx_unsupported <= code_bad;
            if (!code_bad)
            begin
               rx_base_rate <= f_rate;
               rx_bandwidth <= f_bw;
               rx_tc_type <= f_type;
               rx_tc_rate <= f_tcr;
            end
         end
      end
   end

   // Count and bitmap words follow the header
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_pos <= '0;
         rx_count <= '0;
         rx_slot_map <= '0;
      end
      else if (rx_valid)
      begin
         if (rx_sof)
            rx_pos <= ver_ok ? 2'h1 : 2'h0;
         else if (rx_pos == 2'h1)
         begin
            rx_count <= rx_word;
            rx_pos <= 2'h2;
         end
         else if (rx_pos == 2'h2)
         begin
            rx_slot_map <= rx_word;
            rx_pos <= 2'h0;
         end
      end
   end

   // Slots per channel: software override beats the received default
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         slots_per_channel <= 6'h01;
      else if (bw_override_en)
         slots_per_channel <= bw_override;
      else
         slots_per_channel <= 6'h01 << rx_bandwidth[2:0];
   end

   // ==========================================================
   // Checks
   hdr_version_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tx_valid && tx_sof |-> tx_word[27:24] == 4'h3 && tx_word[30] == 1'b0)
      else $error("header version wrong or reserved bit set");
   hdr_rate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(tx_valid && tx_sof) && !$past(network_timing_master)
      |-> tx_word[19:16] == $past(rx_base_rate))
      else $error("slave did not forward received base rate");
   count_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(tx_frame_count) |-> tx_frame_count == $past(tx_frame_count) + 32'h1)
      else $error("frame counter stepped by other than one");
   count_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tx_valid && tx_sof && tx_ready && tc_is_count |=> tx_valid && !tx_sof
      && tx_word == $past(tx_frame_count))
      else $error("count word not the pre-step frame count");
   frame_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tx_valid && tx_sof && tx_ready ##1 tx_ready [*8] |-> !tx_eof)
      else $error("frame ended too early");
   cp_block_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_valid && rx_sof && ver_ok && rx_word[31] |=> !retransmit_allow)
      else $error("copy-protected frame left retransmission open");
   keep_cfg_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_valid && rx_sof && ver_ok && code_bad |=> $stable(rx_base_rate)
      && $stable(rx_bandwidth) && rx_unsupported)
      else $error("reserved code altered configuration");
   bw_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !bw_override_en && rx_bandwidth == 4'h5 |=> slots_per_channel == 6'h20)
      else $error("bandwidth code 5 not 32 slots");
   period_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      frame_tick |=> !frame_tick [*8])
      else $error("frame ticks too close together");
endmodule : fcs_framer

//--- core/fcs_pkg.sv
// Package of field layouts, codes and timing counts for the frame header framer
package fcs_pkg;
   // ==========================================================
   // Clock and frame timing
   localparam int CLK_HZ = 10_000_000;
   localparam int RATE48_HZ = 48_000;
   localparam int RATE44_DHZ = 441_000; // 44.1 kHz in tenths of Hz
   localparam logic [7:0] PERIOD48 = 8'(CLK_HZ / RATE48_HZ);
   localparam logic [7:0] PERIOD44 = 8'((CLK_HZ * 10) / RATE44_DHZ);

   // ==========================================================
   // Header octet positions; octets 30 to 33 make up word 0
   localparam int OCT_VER_CP = 30;
   localparam int OCT_RATE_BW = 31;
   localparam int OCT_TC = 32;
   localparam int OCT_CABLE = 33;
   localparam int OCT_COUNT = 34;
   localparam int OCT_MAP = 38;
   localparam int OCT_SLOT0 = 42;
   localparam int OCT_SLOT_LAST = 166;
   localparam int NUM_SLOTS = 32;

   // ==========================================================
   // Field positions within header word 0 (octet 30 in bits 31:24)
   localparam int VER_LSB = 24;
   localparam int FMT_LSB = 28;
   localparam int CP_BIT = 31;
   localparam int RATE_LSB = 16;
   localparam int BW_LSB = 20;
   localparam int TCRATE_LSB = 10;
   localparam int TCTYPE_LSB = 13;
   localparam int CABLE_LSB = 0;

   // ==========================================================
   // Codes and limits
   localparam logic [3:0] FRAME_VERSION = 4'h3;
   localparam logic [3:0] RATE_48K = 4'h0;
   localparam logic [3:0] RATE_44K1 = 4'h1;
   localparam logic [3:0] BW_MAX = 4'h5;
   localparam logic [2:0] TCTYPE_COUNT = 3'h0;
   localparam logic [2:0] TCTYPE_MAX = 3'h2;
   localparam logic [2:0] TCRATE_MAX = 3'h4;
   localparam int FIFO_DEPTH = 4;
   localparam int SLOT_IDX_W = 5;
   localparam int FIFO_W = SLOT_IDX_W + 32;

   // Transmit sequencer states
   typedef enum logic [2:0]
   {
      FCS_IDLE = 3'b000,
      FCS_HDR = 3'b001,
      FCS_CNT = 3'b010,
      FCS_MAP = 3'b011,
      FCS_SLOT = 3'b100
   } fcs_tx_state_t;
endpackage : fcs_pkg

//--- core/fcs_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module fcs_fifo #(
   parameter int WIDTH = 37,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic do_wr;
   logic do_rd;

   // ==========================================================
   // Handshakes; full and empty come straight from the fill count
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   // Storage, written only on an accepted push
   always_ff @(posedge clk_sys)
   begin
      if (do_wr)
         mem[wr_ptr] <= in_data;
   end

   // Pointers and fill count
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (do_wr)
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         if (do_rd)
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         if (do_wr && !do_rd)
            count <= count + 1'b1;
         else if (do_rd && !do_wr)
            count <= count - 1'b1;
      end
   end
endmodule : fcs_fifo

//--- core/fcs_dummy_unused.sv
`timescale 1ns/1ps
// (none)

//--- tb/fcs_neighbour.sv
// Neighbour device model: sink of the transmit stream, source of the receive stream
`timescale 1ns/1ps
module fcs_neighbour (
   // Clock
   input wire logic clk_sys,
   // Transmit stream from the framer
   input wire logic tx_valid,
   input wire logic [31:0] tx_word,
   input wire logic tx_sof,
   input wire logic tx_eof,
   output logic tx_ready,
   // Receive stream into the framer
   output logic rx_valid,
   output logic rx_sof,
   output logic [31:0] rx_word,
   // Bench control
   input wire logic stall
);
   // ==========================================================
   // Captured frame and timing
   logic [31:0] frame_buf [0:34];
   int idx = 0;
   int frames = 0;
   int cyc = 0;
   int sof_cyc = 0;
   int gap = 0;

   // Sink takes every beat unless the bench asks for a stall
   assign tx_ready = !stall;

   // Start of frame recorded so the frame period can be measured
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (tx_valid && tx_ready)
      begin
         if (tx_sof)
         begin
            frame_buf[0] <= tx_word;
            idx <= 1;
            gap <= cyc - sof_cyc;
            sof_cyc <= cyc;
         end
         else if (idx < 35)
         begin
            frame_buf[idx] <= tx_word;
            idx <= idx + 1;
         end
         if (tx_eof)
            frames <= frames + 1;
      end
   end

   // Receive line starts low: valid, start of frame and word all zero; send_hdr later leaves the word at the inverted bitmap
   initial
   begin
      rx_valid = 1'b0;
      rx_sof = 1'b0;
      rx_word = 32'h0000_0000;
   end

   // Header, count and bitmap sent back to back
   task automatic send_hdr(input logic [31:0] hdr, input logic [31:0] cnt,
                           input logic [31:0] map);
      logic [31:0] w [0:2];
      w = '{hdr, cnt, map};
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk_sys);
         #1;
         rx_valid = 1'b1;
         rx_sof = (i == 0);
         rx_word = w[i];
      end
      @(posedge clk_sys);
      #1;
      rx_valid = 1'b0;
      rx_sof = 1'b0;
      rx_word = ~w[2];
   endtask : send_hdr
endmodule : fcs_neighbour

//--- tb/fcs_framer_tb.sv
// Self-checking bench for the frame header framer
`timescale 1ns/1ps
module fcs_framer_tb;
   // ==========================================================
   // Signals
   logic clk_sys, resetn, network_timing_master, cfg_copy_protect, bw_override_en, stall;
   logic [3:0] cfg_base_rate, cfg_bandwidth, cfg_cable, rx_base_rate, rx_bandwidth, rx_cable;
   logic [1:0] cfg_slot_format;
   logic [2:0] cfg_tc_type, cfg_tc_rate, rx_tc_type, rx_tc_rate;
   logic [31:0] cfg_timecode, slot_in_data, tx_word, rx_word, rx_count, rx_slot_map;
   logic [31:0] tx_frame_count, c;
   logic [5:0] bw_override, slots_per_channel;
   logic [4:0] slot_in_index;
   logic slot_in_valid, slot_in_ready, tx_valid, tx_sof, tx_eof, tx_ready, rx_valid, rx_sof;
   logic rx_version_bad, rx_unsupported, retransmit_allow;
   int errors = 0;
   int cmp_count = 0;
   int acc;
   bit ok;

   fcs_framer i_dut (.clk_sys(clk_sys), .resetn(resetn),
      .network_timing_master(network_timing_master), .cfg_base_rate(cfg_base_rate),
      .cfg_bandwidth(cfg_bandwidth), .cfg_slot_format(cfg_slot_format),
      .cfg_tc_type(cfg_tc_type), .cfg_tc_rate(cfg_tc_rate), .cfg_cable(cfg_cable),
      .cfg_copy_protect(cfg_copy_protect), .cfg_timecode(cfg_timecode),
      .bw_override_en(bw_override_en), .bw_override(bw_override),
      .slot_in_valid(slot_in_valid), .slot_in_index(slot_in_index),
      .slot_in_data(slot_in_data), .slot_in_ready(slot_in_ready), .tx_valid(tx_valid),
      .tx_word(tx_word), .tx_sof(tx_sof), .tx_eof(tx_eof), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_word(rx_word), .rx_base_rate(rx_base_rate),
      .rx_bandwidth(rx_bandwidth), .rx_tc_type(rx_tc_type), .rx_tc_rate(rx_tc_rate),
      .rx_cable(rx_cable), .rx_count(rx_count), .rx_slot_map(rx_slot_map),
      .rx_version_bad(rx_version_bad), .rx_unsupported(rx_unsupported),
      .retransmit_allow(retransmit_allow), .slots_per_channel(slots_per_channel),
      .tx_frame_count(tx_frame_count));

   fcs_neighbour i_nb (.clk_sys(clk_sys), .tx_valid(tx_valid), .tx_word(tx_word),
      .tx_sof(tx_sof), .tx_eof(tx_eof), .tx_ready(tx_ready), .rx_valid(rx_valid),
      .rx_sof(rx_sof), .rx_word(rx_word), .stall(stall));

   // 10 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // ==========================================================
   // Helpers
   function automatic logic [31:0] hdr(input logic cp, input logic [1:0] fmt,
      input logic [3:0] bw, input logic [3:0] rate, input logic [2:0] ty,
      input logic [2:0] tr, input logic [3:0] cab);
      return {cp, 1'b0, fmt, fcs_pkg::FRAME_VERSION, bw, rate, ty, tr, 2'b00, 4'h0, cab};
   endfunction : hdr

   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         #1;
      end
   endtask : tick

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         errors++;
      end
   endtask : chk

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run

   // Bounded wait for n more complete frames at the sink
   task automatic wait_frames(input int n);
      int target;
      target = i_nb.frames + n;
      for (int i = 0; i < 2000 * n && i_nb.frames < target; i++)
         tick(1);
      if (i_nb.frames < target)
      begin
         $display("wrong value frame wait expected %0d seen %0d", target, i_nb.frames);
         errors++;
         complete_run();
      end
   endtask : wait_frames

   // Valid held until the edge where ready is high; gives up after four edges
   task automatic try_push(input logic [4:0] ix, input logic [31:0] d, output bit got);
      got = 1'b0;
      slot_in_valid = 1'b1;
      slot_in_index = ix;
      slot_in_data = d;
      for (int i = 0; i < 4 && !got; i++)
      begin
         if (slot_in_ready === 1'b1)
            got = 1'b1;
         tick(1);
      end
      slot_in_valid = 1'b0;
      tick(1);
   endtask : try_push

   // ==========================================================
   // Main sequence
   initial
   begin
      {network_timing_master, cfg_copy_protect, bw_override_en, stall, slot_in_valid} = '0;
      {cfg_base_rate, cfg_bandwidth, cfg_cable, cfg_slot_format, cfg_tc_type} = '0;
      {cfg_tc_rate, cfg_timecode, bw_override, slot_in_index, slot_in_data} = '0;
      resetn = 1'b0;
      tick(20);
      resetn = 1'b1;
      tick(3);
      // Master transmit with two slots filled
      network_timing_master = 1'b1;
      {cfg_copy_protect, cfg_slot_format, cfg_bandwidth, cfg_tc_rate, cfg_cable} =
         {1'b1, 2'h1, 4'h2, 3'h3, 4'h5};
      try_push(5'h00, 32'h1234_5678, ok);
      chk("push0", 32'h1, 32'(ok));
      try_push(5'h1f, 32'hcafe_0001, ok);
      chk("push31", 32'h1, 32'(ok));
      wait_frames(1);
      chk("header", hdr(1, 1, 2, 0, 0, 3, 5), i_nb.frame_buf[0]);
      chk("bitmap", 32'h8000_0001, i_nb.frame_buf[2]);
      chk("slot0", 32'h1234_5678, i_nb.frame_buf[3]);
      chk("slot1", 32'h0000_0000, i_nb.frame_buf[4]);
      chk("slot31", 32'hcafe_0001, i_nb.frame_buf[34]);
      c = i_nb.frame_buf[1];
      wait_frames(1);
      chk("count", c + 32'h1, i_nb.frame_buf[1]);
      chk("txcount", c + 32'h2, tx_frame_count);
      chk("period48", 32'd208, 32'(i_nb.gap));
      cfg_base_rate = 4'h1;
      wait_frames(3);
      chk("period44", 32'd226, 32'(i_nb.gap));
      chk("mrate", 32'h1, 32'(i_nb.frame_buf[0][19:16]));
      $display("test master transmit done");
      // Stall at a frame header: fifo fills, a tick is dropped, counter steps once
      wait_frames(1);
      c = i_nb.frame_buf[1];
      stall = 1'b1;
      for (int i = 0; i < 400 && tx_valid !== 1'b1; i++)
         tick(1);
      chk("stallhead", 32'h1, 32'(tx_valid));
      acc = 0;
      for (int i = 4; i < 9; i++)
      begin
         try_push(5'(i), 32'(i) + 32'ha000_0000, ok);
         acc += int'(ok);
      end
      chk("fill", 32'd4, 32'(acc));
      tick(300);
      stall = 1'b0;
      wait_frames(1);
      chk("cntstall", c + 32'h1, i_nb.frame_buf[1]);
      wait_frames(1);
      chk("bitmap4", 32'h0000_00f0, i_nb.frame_buf[2] & 32'h0000_01f0);
      chk("slot4", 32'ha000_0004, i_nb.frame_buf[7]);
      $display("test buffer stall done");
      // Receive every defined code
      for (int i = 0; i < 6; i++)
      begin
         i_nb.send_hdr(hdr(0, 0, 4'(i), 4'(i % 2), 3'(i % 3), 3'(i % 5), 4'(i)),
            32'h0000_00aa, 32'h0f0f_0001);
         tick(2);
         chk("rxrate", 32'(i % 2), 32'(rx_base_rate));
         chk("rxbw", 32'(i), 32'(rx_bandwidth));
         chk("slots", 32'h1 << i, 32'(slots_per_channel));
         chk("rxtype", 32'(i % 3), 32'(rx_tc_type));
         chk("rxtcr", 32'(i % 5), 32'(rx_tc_rate));
         chk("rxcable", 32'(i), 32'(rx_cable));
      end
      chk("rxcount", 32'h0000_00aa, rx_count);
      chk("rxmap", 32'h0f0f_0001, rx_slot_map);
      chk("flags", 32'h1, {rx_version_bad, rx_unsupported, retransmit_allow});
      bw_override = 6'd5;
      bw_override_en = 1'b1;
      tick(2);
      chk("override", 32'd5, 32'(slots_per_channel));
      bw_override_en = 1'b0;
      // Reserved codes, one field at a time
      for (int f = 0; f < 4; f++)
      begin
         i_nb.send_hdr(hdr(0, 0, f == 1 ? 4'h6 : 4'h5, f == 0 ? 4'h2 : 4'h1,
            f == 2 ? 3'h3 : 3'h2, f == 3 ? 3'h5 : 3'h0, 4'hc), 32'h1, 32'h1);
         tick(2);
         chk("unsup", 32'h1, 32'(rx_unsupported));
         chk("kept", 32'h0051_4000, {rx_bandwidth, rx_base_rate, rx_tc_type, rx_tc_rate, 10'h0});
         chk("cable", 32'hc, 32'(rx_cable));
      end
      i_nb.send_hdr(hdr(0, 0, 1, 0, 0, 0, 3) ^ 32'h0100_0000, 32'h1, 32'h1);
      tick(2);
      chk("verbad", 32'h1, 32'(rx_version_bad));
      chk("verkept", 32'hc, 32'(rx_cable));
      i_nb.send_hdr(hdr(1, 0, 1, 0, 0, 0, 3), 32'h1, 32'h1);
      tick(2);
      chk("cpblock", 32'h0, 32'(retransmit_allow));
      i_nb.send_hdr(hdr(0, 0, 1, 0, 0, 0, 3), 32'h1, 32'h1);
      tick(2);
      chk("cpclear", 32'h1, 32'(retransmit_allow));
      $display("test receive done");
      // Non-master forwards the rate received on its OUT side
      network_timing_master = 1'b0;
      cfg_base_rate = 4'h0;
      cfg_tc_type = 3'h1;
      cfg_timecode = 32'h1357_9bdf;
      i_nb.send_hdr(hdr(0, 0, 1, 1, 0, 0, 3), 32'h1, 32'h1);
      wait_frames(2);
      chk("fwdrate", 32'h1, 32'(i_nb.frame_buf[0][19:16]));
      chk("tctype", 32'h1, 32'(i_nb.frame_buf[0][15:13]));
      chk("timecode", 32'h1357_9bdf, i_nb.frame_buf[1]);
      $display("test forward done");
      complete_run();
   end
endmodule : fcs_framer_tb
